// ---- verilog/cpu_exec_defines.svh ----
`ifndef CPU_EXEC_DEFINES_SVH
`define CPU_EXEC_DEFINES_SVH
// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_ADC_IMM 8'h69
`define OP_ADC_ABX 8'h7D
`define OP_ADC_ABY 8'h79
`define OP_ADC_INY 8'h71
`define OP_AND_IMM 8'h29
`define OP_AND_ABX 8'h3D
`define OP_AND_ABY 8'h39
`define OP_AND_INX 8'h21
`define OP_AND_INY 8'h31
`define OP_SHL_ACC 8'h0A
`define OP_SHL_ZP 8'h06
`define OP_BIT_ZP 8'h24
`define OP_BIT_ABS 8'h2C
`define OP_BR_PLUS 8'h10
`define OP_BR_MINUS 8'h30
`define OP_BR_OVF_CLR 8'h50
`define OP_BR_OVF_SET 8'h70
`define OP_BR_CARRY_CLR 8'h90
`define OP_BR_CARRY_SET 8'hB0
`define OP_BR_NOT_EQUAL 8'hD0
`define OP_BR_EQUAL 8'hF0
`define OP_SWBRK 8'h00
// ----------------------------------------
// status bit positions and timing
// ----------------------------------------
`define ST_C 0
`define ST_Z 1
`define ST_I 2
`define ST_B 4
`define ST_V 6
`define ST_N 7
`define ST_RESET 8'h24
`define SP_RESET 8'hFF
`define PROGRAM_COUNTER_RESET 16'h0000
`define BREAK_VEC 16'hFFFE
`define BREAK_CYCLES 7
`define BRANCH_BASE 2
`endif

// ---- verilog/cpu_exec_pkg.sv ----
package cpu_exec_pkg;
  // alu result carrier
  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic v;
  } alu_out_s;
  // alu operation select
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0,
    ALU_AND = 3'h1,
    ALU_SHL = 3'h2,
    ALU_BIT = 3'h3,
    ALU_PASS = 3'h4
  } alu_op_e;
endpackage : cpu_exec_pkg

// ---- verilog/cpu_alu.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_alu (
  // operands
  input wire logic [7:0] a,
  input wire logic [7:0] m,
  input wire logic cin,
  input wire cpu_exec_pkg::alu_op_e op,
  // result
  output cpu_exec_pkg::alu_out_s y
);
  logic [8:0] sum;
  always_comb begin
    // nine-bit sum keeps carry out
    sum = {1'b0, a} + {1'b0, m} + {8'h00, cin};
    y.res = a;
    y.c = cin;
    y.v = 1'b0;
    unique case (op)
      cpu_exec_pkg::ALU_ADD: begin
        y.res = sum[7:0];
        y.c = sum[8];
        y.v = (a[7] == m[7]) && (sum[7] != a[7]);
      end
      cpu_exec_pkg::ALU_AND: y.res = a & m;
      cpu_exec_pkg::ALU_SHL: begin
        y.res = {m[6:0], 1'b0};
        y.c = m[7];
      end
      cpu_exec_pkg::ALU_BIT: y.res = a & m;
      cpu_exec_pkg::ALU_PASS: y.res = m;
      default: y.res = a;
    endcase
  end
endmodule : cpu_alu
`default_nettype wire

// ---- verilog/cpu_stack_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_stack_mem #(
  parameter int DEPTH = 256
) (
  // clock
  input wire logic clock,
  // write port
  input wire logic we,
  input wire logic [7:0] waddr,
  input wire logic [7:0] wdata,
  // read port, registered
  input wire logic [7:0] raddr,
  output logic [7:0] rdata
);
  // stack page storage, no reset on purpose
  logic [7:0] mem [DEPTH];
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : cpu_stack_mem
`default_nettype wire

// ---- verilog/cpu_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "cpu_exec_defines.svh"
module cpu_exec (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // instruction bus: opcode and operands presented with start
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand,
  input wire logic page_cross,
  input wire logic [15:0] vector,
  // architectural state out
  output logic [7:0] acc_q,
  output logic [7:0] status_q,
  output logic [15:0] program_counter_q,
  output logic [7:0] sp_q,
  // timing and stack top
  output logic busy_q,
  output logic done_q,
  output logic [3:0] cycles_q,
  output logic [7:0] stack_top_q
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b100
  } state_e;
  state_e state_q;
  logic [3:0] count_q; // cycles left
  cpu_exec_pkg::alu_op_e op;
  cpu_exec_pkg::alu_out_s alu_y;
  logic is_branch, taken, is_break, writes_acc; // decode flags
  logic [15:0] fall_addr, target; // next instruction and branch target
  logic [3:0] cost;
  logic st_we;
  logic [7:0] st_addr, st_data;
  logic [1:0] push_q; // break pushes remaining
  logic [7:0] mem_rd;

  // branch condition from opcode bits 7:6 and 5
  function automatic logic cond_met(input logic [7:0] o, input logic [7:0] p);
    logic f;
    f = 1'b0;
    unique case (o[7:6])
      2'b00: f = p[`ST_N];
      2'b01: f = p[`ST_V];
      2'b10: f = p[`ST_C];
      2'b11: f = p[`ST_Z];
    endcase
    return f == o[5];
  endfunction : cond_met

  // bytes taken by an instruction; absolute forms carry a two-byte address
  function automatic logic [15:0] insn_len(input logic [7:0] o);
    logic [15:0] n;
    n = 16'h0002;
    // accumulator shift has no operand byte
    if (o == `OP_SHL_ACC) n = 16'h0001;
    if (o == `OP_ADC_ABX || o == `OP_ADC_ABY || o == `OP_AND_ABX || o == `OP_AND_ABY
        || o == `OP_BIT_ABS) n = 16'h0003;
    return n;
  endfunction : insn_len

  always_comb begin
    is_branch = (opcode[4:0] == 5'h10);
    is_break = (opcode == `OP_SWBRK);
    op = cpu_exec_pkg::ALU_PASS;
    writes_acc = 1'b0;
    unique case (opcode)
      `OP_ADC_IMM, `OP_ADC_ABX, `OP_ADC_ABY, `OP_ADC_INY: begin
        op = cpu_exec_pkg::ALU_ADD;
        writes_acc = 1'b1;
      end
      `OP_AND_IMM, `OP_AND_ABX, `OP_AND_ABY, `OP_AND_INX, `OP_AND_INY: begin
        op = cpu_exec_pkg::ALU_AND;
        writes_acc = 1'b1;
      end
      `OP_SHL_ACC, `OP_SHL_ZP: op = cpu_exec_pkg::ALU_SHL;
      `OP_BIT_ZP, `OP_BIT_ABS: op = cpu_exec_pkg::ALU_BIT;
      default: op = cpu_exec_pkg::ALU_PASS;
    endcase
  end

  // ----------------------------------------
  // alu
  // ----------------------------------------
  cpu_alu u_alu (
    .a(acc_q),
    .m((opcode == `OP_SHL_ACC) ? acc_q : operand),
    .cin(status_q[`ST_C]),
    .op(op),
    .y(alu_y)
  );

  // ----------------------------------------
  // branch target and cycle cost
  // ----------------------------------------
  always_comb begin
    fall_addr = is_break ? program_counter_q + 16'h0001 : program_counter_q + 16'h0002;
    target = fall_addr + {{8{operand[7]}}, operand};
    taken = is_branch && cond_met(opcode, status_q);
    cost = 4'd2;
    if (is_break) begin
      cost = 4'(`BREAK_CYCLES);
    end else if (is_branch) begin
      cost = 4'(`BRANCH_BASE);
      if (taken) begin
        cost = (target[15:8] == fall_addr[15:8]) ? 4'd3 : 4'd4;
      end
    end else if (op == cpu_exec_pkg::ALU_ADD || op == cpu_exec_pkg::ALU_AND) begin
      // page cross penalty on indexed modes other than OP_AND_INX
      cost = 4'd4;
      if (opcode == `OP_ADC_IMM || opcode == `OP_AND_IMM) cost = 4'd2;
      if (opcode == `OP_AND_INX) cost = 4'd6;
      if (opcode == `OP_ADC_INY || opcode == `OP_AND_INY) cost = 4'd5;
      if (page_cross && opcode != `OP_ADC_IMM && opcode != `OP_AND_IMM
          && opcode != `OP_AND_INX) cost = cost + 4'd1;
    end else if (opcode == `OP_SHL_ZP) begin
      cost = 4'd5;
    end else if (opcode == `OP_BIT_ZP) begin
      cost = 4'd3;
    end else if (opcode == `OP_BIT_ABS) begin
      cost = 4'd4;
    end
  end

  // ----------------------------------------
  // sequencing
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      count_q <= 4'h0;
      cycles_q <= 4'h0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start) begin
          state_q <= (cost > 4'd1) ? ST_WAIT : ST_DONE;
          count_q <= cost - 4'd2;
          cycles_q <= cost;
        end
        ST_WAIT: if (count_q == 4'h0) begin
          state_q <= ST_DONE;
        end else begin
          count_q <= count_q - 4'd1;
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // busy and done flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      busy_q <= (state_q == ST_IDLE) ? start : (state_q == ST_WAIT);
      done_q <= (state_q == ST_WAIT) && (count_q == 4'h0);
    end
  end

  // ----------------------------------------
  // architectural state, committed at start
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_q <= 8'h00;
      status_q <= `ST_RESET;
      program_counter_q <= `PROGRAM_COUNTER_RESET;
    end else if (state_q == ST_IDLE && start) begin
      if (writes_acc || opcode == `OP_SHL_ACC) acc_q <= alu_y.res;
      if (op == cpu_exec_pkg::ALU_ADD || op == cpu_exec_pkg::ALU_AND
          || op == cpu_exec_pkg::ALU_SHL) begin
        status_q[`ST_N] <= alu_y.res[7];
        status_q[`ST_Z] <= (alu_y.res == 8'h00);
      end
      if (op == cpu_exec_pkg::ALU_ADD) begin
        status_q[`ST_C] <= alu_y.c;
        status_q[`ST_V] <= alu_y.v;
      end
      if (op == cpu_exec_pkg::ALU_SHL) status_q[`ST_C] <= alu_y.c;
      if (op == cpu_exec_pkg::ALU_BIT) begin
        status_q[`ST_N] <= operand[7];
        status_q[`ST_V] <= operand[6];
        status_q[`ST_Z] <= (alu_y.res == 8'h00);
      end
      if (is_break) begin
        status_q[`ST_I] <= 1'b1;
        program_counter_q <= vector;
      end else if (taken) begin
        program_counter_q <= target;
      end else begin
        program_counter_q <= program_counter_q + insn_len(opcode);
      end
    end
  end

  // ----------------------------------------
  // break stacking: return high, return low, status
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      push_q <= 2'h0;
      sp_q <= `SP_RESET;
    end else if (state_q == ST_IDLE && start && is_break) begin
      push_q <= 2'h3;
    end else if (push_q != 2'h0) begin
      push_q <= push_q - 2'h1;
      sp_q <= sp_q - 8'h01;
    end
  end

  logic [15:0] ret_q; // saved return address
  logic [7:0] pst_q; // saved status
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ret_q <= 16'h0000;
      pst_q <= 8'h00;
    end else if (state_q == ST_IDLE && start && is_break) begin
      ret_q <= program_counter_q + 16'h0002;
      pst_q <= status_q | (8'h01 << `ST_B);
    end
  end

  always_comb begin
    st_we = (push_q != 2'h0);
    st_addr = sp_q;
    unique case (push_q)
      2'h3: st_data = ret_q[15:8];
      2'h2: st_data = ret_q[7:0];
      default: st_data = pst_q;
    endcase
  end

  cpu_stack_mem #(.DEPTH(256)) u_stack (
    .clock(clock),
    .we(st_we),
    .waddr(st_addr),
    .wdata(st_data),
    .raddr(sp_q + 8'h01),
    .rdata(mem_rd)
  );

  // last pushed byte, visible
  always_ff @(posedge clock or posedge rst) begin
    if (rst) stack_top_q <= 8'h00;
    else stack_top_q <= mem_rd;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_break_seven_cycles: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && start && is_break) |=> cycles_q == 4'd7)
    else $error("break cost wrong");
  a_branch_no_flags: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && start && is_branch) |=> status_q == $past(status_q))
    else $error("branch changed flags");
  a_break_sets_i: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && start && is_break) |=> status_q[`ST_I])
    else $error("break left I clear");
  a_taken_target: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && start && taken) |=> program_counter_q == $past(target))
    else $error("branch target wrong");
  a_bit_acc_kept: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && start && op == cpu_exec_pkg::ALU_BIT) |=> acc_q == $past(acc_q))
    else $error("bit test wrote accumulator");
  a_break_pushes: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && start && is_break) |=> ##3 sp_q == $past(sp_q, 4) - 8'h03)
    else $error("break pushed wrong count");
  a_untaken_base: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && start && is_branch && !taken) |=> cycles_q == 4'd2)
    else $error("untaken branch cost wrong");
  a_done_after_cost: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && start && cost == 4'd2) |=> ##1 done_q)
    else $error("done late");
  // shift moves the old bit 7 into carry, from the accumulator or the operand
  a_shift_carry: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && start && op == cpu_exec_pkg::ALU_SHL)
    |=> status_q[`ST_C] == (($past(opcode) == `OP_SHL_ACC) ? $past(acc_q[7])
                                                           : $past(operand[7])))
    else $error("shift carry wrong");
  // logical and leaves carry and overflow alone
  a_and_keeps_cv: assert property (@(posedge clock) disable iff (rst)
    (state_q == ST_IDLE && start && op == cpu_exec_pkg::ALU_AND)
    |=> status_q[`ST_C] == $past(status_q[`ST_C])
        && status_q[`ST_V] == $past(status_q[`ST_V]))
    else $error("and touched carry or overflow");
endmodule : cpu_exec
`default_nettype wire

// ---- test/sys_mem.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// far side: memory holding the break vector
// ----------------------------------------
module sys_mem #(
  // vector target, arbitrary test value
  parameter logic [15:0] BREAK_TARGET = 16'h8AF0
) (
  // vector bytes as read from the top of memory
  output logic [15:0] vector
);
  // low and high vector bytes
  logic [7:0] vec_lo;
  logic [7:0] vec_hi;
  assign vec_lo = BREAK_TARGET[7:0];
  assign vec_hi = BREAK_TARGET[15:8];
  assign vector = {vec_hi, vec_lo};
endmodule : sys_mem
`default_nettype wire

// ---- test/cpu_alu_branch_break_decode_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("FAIL %0t got %h exp %h", $time, (g), (e)); end end
module cpu_alu_branch_break_decode_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  // stimulus, all given at time zero
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] operand = 8'h00;
  logic page_cross = 1'b0;
  logic [15:0] vector;
  // design outputs
  logic [7:0] acc_q, status_q, sp_q, stack_top_q;
  logic [15:0] program_counter_q;
  logic busy_q, done_q;
  logic [3:0] cycles_q;
  // expected state kept by the bench
  logic [7:0] e_acc, e_st, e_sp, e_push;
  logic [15:0] e_prog;
  int errors = 0;
  int n_checks = 0;
  // branch opcodes and offsets, offsets mix same and other page
  logic [7:0] br_op [8] = '{8'h10, 8'h30, 8'h50, 8'h70, 8'h90, 8'hB0, 8'hD0, 8'hF0};
  logic [7:0] br_off [4] = '{8'h7F, 8'h02, 8'h80, 8'hFE};
  logic [7:0] sh_m [4] = '{8'h80, 8'h00, 8'h80, 8'h01};
  logic [7:0] bit_m [4] = '{8'hC0, 8'h00, 8'h40, 8'h80};
  always #5 clock = ~clock;
  // ----------------------------------------
  // partner and design
  // ----------------------------------------
  sys_mem mem (.vector(vector));
  cpu_exec dut (.clock(clock), .rst(rst), .start(start), .opcode(opcode),
    .operand(operand), .page_cross(page_cross), .vector(vector), .acc_q(acc_q),
    .status_q(status_q), .program_counter_q(program_counter_q), .sp_q(sp_q),
    .busy_q(busy_q), .done_q(done_q), .cycles_q(cycles_q), .stack_top_q(stack_top_q));
  // ----------------------------------------
  // reference model of one instruction
  // ----------------------------------------
  task automatic model(input logic [7:0] op, input logic [7:0] m, input logic px,
    output int cost);
    logic [8:0] sum;
    logic [15:0] nxt;
    logic [7:0] r;
    logic nz;
    cost = 2;
    nz = 1'b1;
    r = e_acc;
    nxt = e_prog + 16'h0002;
    case (op)
      8'h69, 8'h7D, 8'h79, 8'h71: begin
        sum = {1'b0, e_acc} + {1'b0, m} + {8'h00, e_st[0]};
        e_st[6] = ~(e_acc[7] ^ m[7]) & (e_acc[7] ^ sum[7]);
        e_st[0] = sum[8];
        r = sum[7:0];
      end
      8'h29, 8'h3D, 8'h39, 8'h21, 8'h31: r = e_acc & m;
      8'h0A: begin
        e_st[0] = e_acc[7];
        r = {e_acc[6:0], 1'b0};
      end
      8'h06: begin
        e_st[0] = m[7];
        r = e_acc;
        e_st[7] = m[6];
        e_st[1] = (m[6:0] == 7'h00);
        nz = 1'b0;
      end
      8'h24, 8'h2C: begin
        e_st[7] = m[7];
        e_st[6] = m[6];
        e_st[1] = ((e_acc & m) == 8'h00);
        nz = 1'b0;
      end
      8'h00: begin
        e_push = e_st | 8'h10;
        e_st[2] = 1'b1;
        e_sp = e_sp - 8'h03;
        nxt = vector;
        nz = 1'b0;
      end
      default: nz = 1'b0;
    endcase
    if (nz) begin
      e_acc = r;
      e_st[7] = r[7];
      e_st[1] = (r == 8'h00);
    end
    case (op)
      8'h7D, 8'h79, 8'h3D, 8'h39: cost = 4 + int'(px);
      8'h71, 8'h31: cost = 5 + int'(px);
      8'h21: cost = 6;
      8'h06: cost = 5;
      8'h24: cost = 3;
      8'h2C: cost = 4;
      8'h00: cost = 7;
      default: ;
    endcase
    // three-byte forms and the one-byte shift
    if (op inside {8'h7D, 8'h79, 8'h3D, 8'h39, 8'h2C}) nxt = e_prog + 16'h0003;
    if (op == 8'h0A) nxt = e_prog + 16'h0001;
    // branch: flag chosen by top bits, wanted level by bit 5
    if (op[4:0] == 5'h10 && e_st[op[7:6] == 2'h0 ? 7 : op[7:6] == 2'h1 ? 6 :
        op[7:6] == 2'h2 ? 0 : 1] == op[5]) begin
      r = nxt[15:8];
      nxt = nxt + {{8{m[7]}}, m};
      cost = (nxt[15:8] == r) ? 3 : 4;
    end
    e_prog = nxt;
  endtask : model
  // ----------------------------------------
  // one instruction, with optional refused start while busy
  // ----------------------------------------
  task automatic run(input logic [7:0] op, input logic [7:0] m, input logic px,
    input logic poke);
    int cost;
    int n;
    model(op, m, px, cost);
    opcode = op;
    operand = m;
    page_cross = px;
    start = 1'b1;
    @(posedge clock);
    #1 start = 1'b0;
    `CHK(busy_q, 1'b1)
    n = 0;
    // bounded wait for the completion pulse; n counts edges after the taking one
    while (done_q !== 1'b1 && n < 20) begin
      // a second start while busy must be ignored
      if (n == 1 && poke) begin
        opcode = 8'h69;
        operand = 8'h55;
        start = 1'b1;
      end
      if (n == 2 && poke) start = 1'b0;
      @(posedge clock);
      #1 n++;
    end
    // done marks the last cycle, so the cost is one edge more
    `CHK(n + 1, cost)
    `CHK(cycles_q, cost[3:0])
    `CHK(acc_q, e_acc)
    `CHK(status_q, e_st)
    `CHK(program_counter_q, e_prog)
    `CHK(sp_q, e_sp)
    // start is refused during the done cycle, so let it pass
    @(posedge clock);
    #1;
    `CHK(done_q, 1'b0)
    `CHK(busy_q, 1'b0)
    if (op == 8'h00) `CHK(stack_top_q, e_push)
  endtask : run
  // ----------------------------------------
  // verdict
  // ----------------------------------------
  task automatic conclude();
    if (errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    #200000;
    errors++;
    conclude();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    e_acc = 8'h00;
    e_st = 8'h24;
    e_sp = 8'hFF;
    e_prog = 16'h0000;
    run(8'h69, 8'h7F, 1'b0, 1'b0);
    run(8'h69, 8'h01, 1'b0, 1'b0);
    run(8'h69, 8'h80, 1'b0, 1'b0);
    run(8'h7D, 8'h10, 1'b1, 1'b0);
    run(8'h79, 8'hF0, 1'b0, 1'b0);
    run(8'h71, 8'h01, 1'b1, 1'b0);
    run(8'h29, 8'hF3, 1'b0, 1'b0);
    run(8'h3D, 8'hC1, 1'b1, 1'b0);
    run(8'h69, 8'h81, 1'b0, 1'b0);
    run(8'h21, 8'h81, 1'b0, 1'b0);
    run(8'h39, 8'h00, 1'b1, 1'b0);
    run(8'h69, 8'hC0, 1'b0, 1'b0);
    run(8'h31, 8'hFF, 1'b0, 1'b0);
    run(8'h31, 8'h0F, 1'b1, 1'b0);
    run(8'h0A, 8'h00, 1'b0, 1'b0);
    run(8'h0A, 8'h00, 1'b0, 1'b0);
    run(8'h2C, 8'h3F, 1'b0, 1'b0);
    run(8'h00, 8'h00, 1'b0, 1'b1);
    for (int p = 0; p < 4; p++) begin
      run(8'h06, sh_m[p], 1'b0, 1'b0);
      run(8'h24, bit_m[p], 1'b0, 1'b0);
      // each pass pairs a sign or overflow branch with a carry or zero branch
      for (int k = 0; k < 4; k++) begin
        run(br_op[k], br_off[(k + p) % 4], 1'b0, 1'b0);
        run(br_op[k + 4], br_off[(k + p) % 4], 1'b0, 1'b0);
      end
    end
    conclude();
  end
endmodule : cpu_alu_branch_break_decode_tb
`default_nettype wire
